// ---- src/ddrrt_ctl.sv ----
// Controller end: AHB-Lite registers, command spacing, read buffer
`timescale 1ns/1ps
module ddrrt_ctl
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Link
  ddrrt_if.ctl             lnk
);
  import ddrrt_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [25:0] cfg;        // Mode settings
  logic [31:0] wdata;      // Write word
  logic        a_vld;      // Write data phase pending
  logic [7:0]  a_addr;     // Its register offset
  logic        pend;       // Command waiting
  logic [7:0]  pend_cmd;   // Waiting command fields
  logic        go;         // Command issues this cycle
  logic        ok;         // Spacing satisfied
  logic [6:0]  rd2pre;     // Read to precharge countdown
  logic [5:0]  ras;        // Activate to precharge countdown
  logic [5:0]  rp;         // Precharge period countdown
  logic [5:0]  rc;         // Row cycle countdown
  logic [6:0]  wl_cnt;     // Write latency countdown
  logic [3:0]  wbeats;     // Write beats left
  logic [1:0]  wbyte;      // Byte of write word
  logic [31:0] pack;       // Read word being packed
  logic [1:0]  pack_n;     // Bytes packed
  logic        push;       // Packed word ready to store
  logic [31:0] rbuf [2];   // Two entry read buffer
  logic        wp;         // Buffer write pointer
  logic        rpt;        // Buffer read pointer
  logic [1:0]  cnt;        // Buffer fill
  logic        pop;        // Buffer drained by software
  logic        in_ready;   // Buffer can take a word
  logic        rd_phase;   // Read address phase taken
  logic        rd_busy;    // Read bytes still packing or write latency running
  ddrrt_cmd_e  c;          // Waiting command code

  // ****************************************************
  // AHB-Lite slave
  // ****************************************************
  assign rd_phase = hsel && htrans[1] && hready && !hwrite;
  assign pop      = rd_phase && (haddr[7:0] == REG_RDATA) && (cnt != 2'h0);
  assign in_ready = (cnt != 2'h2);
  assign push     = lnk.dq_d2c_vld && (pack_n == 2'h3) && in_ready;

  // Address phase capture, read data registered, zero wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_vld     <= 1'b0;
      a_addr    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      a_vld  <= hsel && htrans[1] && hready && hwrite;
      a_addr <= haddr[7:0];
      if (rd_phase)
      begin
        case (haddr[7:0])
          REG_CFG:   hrdata <= 32'(cfg);
          REG_CMD:   hrdata <= 32'(pend_cmd);
          REG_STAT:  hrdata <= {28'h000_0000, cnt, lnk.dq_d2c_vld, pend};
          REG_RDATA: hrdata <= rbuf[rpt];
          REG_WDATA: hrdata <= wdata;
          default:   hrdata <= '0;
        endcase
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg      <= 26'(CFG_RST);
      wdata    <= '0;
      pend     <= 1'b0;
      pend_cmd <= '0;
    end
    else
    begin
      if (a_vld && (a_addr == REG_CFG))
      begin
        cfg <= hwdata[25:0];
      end
      if (a_vld && (a_addr == REG_WDATA))
      begin
        wdata <= hwdata;
      end
      if (a_vld && (a_addr == REG_CMD))
      begin
        pend     <= 1'b1;
        pend_cmd <= hwdata[7:0];
      end
      else if (go)
      begin
        pend <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Command spacing
  // ****************************************************
  assign c       = ddrrt_cmd_e'(pend_cmd[2:0]);
  assign rd_busy = (pack_n != 2'h0) || (wl_cnt != 7'h00);

  // Whether the waiting command may go now
  always_comb
  begin
    case (c)
      DDRRT_PRE: ok = (rd2pre == 7'h00) && (ras == 6'h00);
      DDRRT_ACT: ok = (rp == 6'h00) && (rc == 6'h00);
      DDRRT_RD,
      DDRRT_RDA: ok = (cnt == 2'h0) && !rd_busy;            // Buffer must be empty
      DDRRT_WR:  ok = (wbeats == 4'h0) && (wl_cnt == 7'h00);
      default:   ok = 1'b1;
    endcase
    go = pend && ok;
  end

  // Drive link command one cycle and the mode settings
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lnk.cmd         <= DDRRT_NOP;
      lnk.a12         <= 1'b0;
      lnk.col         <= '0;
      lnk.burst_field <= BF_FIXED8;
      lnk.rtp_code    <= '0;
      lnk.cl          <= '0;
      lnk.al          <= '0;
      lnk.cas_write_latency         <= CWL_MIN;
      lnk.par_en      <= 1'b0;
      lnk.pl          <= '0;
      lnk.dbi_en      <= 1'b0;
    end
    else
    begin
      lnk.cmd         <= go ? c : DDRRT_NOP;
      lnk.a12         <= pend_cmd[3];
      lnk.col         <= pend_cmd[7:4];
      lnk.burst_field <= cfg[1:0];
      lnk.rtp_code    <= cfg[4:2];
      lnk.cl          <= cfg[9:5];
      lnk.al          <= cfg[14:10];
      // Two-clock preamble raises a minimum write latency
      lnk.cas_write_latency         <= (cfg[25] && (cfg[19:15] <= CWL_MIN)) ? CWL_MIN + 5'h01 : cfg[19:15];
      lnk.par_en      <= cfg[20];
      lnk.pl          <= cfg[23:21];
      lnk.dbi_en      <= cfg[24];
    end
  end

  // Bank timers, each reaches zero when its wait has passed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd2pre <= '0;
      ras    <= '0;
      rp     <= '0;
      rc     <= '0;
    end
    else
    begin
      rd2pre <= (rd2pre != 7'h00) ? rd2pre - 7'h01 : 7'h00;
      ras    <= (ras != 6'h00) ? ras - 6'h01 : 6'h00;
      rp     <= (rp != 6'h00) ? rp - 6'h01 : 6'h00;
      rc     <= (rc != 6'h00) ? rc - 6'h01 : 6'h00;
      if (go && (c == DDRRT_ACT))
      begin
        ras <= ACTIVATE_TO_PRECHARGE_TIME_CYC;
        rc  <= TRC_CYC;
      end
      if (go && ((c == DDRRT_RD) || (c == DDRRT_RDA)))
      begin
        rd2pre <= 7'(cfg[14:10]) + 7'(ddrrt_rtp(cfg[4:2]));
      end
      if (go && (c == DDRRT_RDA))
      begin
        rp <= 6'(7'(cfg[14:10]) + 7'(ddrrt_rtp(cfg[4:2])) + 7'(TRP_CYC));
      end
      if (go && (c == DDRRT_PRE))
      begin
        rp <= TRP_CYC;
      end
    end
  end

  // ****************************************************
  // Write data driver
  // ****************************************************
  // Beat 0 lands wl cycles after the command cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wl_cnt         <= '0;
      wbeats         <= '0;
      wbyte          <= '0;
      lnk.dq_c2d     <= '0;
      lnk.dq_c2d_vld <= 1'b0;
    end
    else
    begin
      lnk.dq_c2d_vld <= 1'b0;
      if (go && (c == DDRRT_WR))
      begin
        wl_cnt <= ddrrt_wr_lat(lnk.cas_write_latency, cfg[14:10], cfg[20], cfg[23:21]);
        wbeats <= ddrrt_is_eight(cfg[1:0], pend_cmd[3]) ? BEATS8 : BEATS4;
        wbyte  <= '0;
      end
      else if (wl_cnt > 7'h01)
      begin
        wl_cnt <= wl_cnt - 7'h01;
      end
      else if (wbeats != 4'h0)
      begin
        wl_cnt         <= '0;
        wbeats         <= wbeats - 4'h1;
        wbyte          <= wbyte + 2'h1;
        lnk.dq_c2d     <= wdata[8 * wbyte +: 8];
        lnk.dq_c2d_vld <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Read packing and two entry buffer
  // ****************************************************
  // Four beats make one word, lowest byte first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pack   <= '0;
      pack_n <= '0;
      wp     <= 1'b0;
      rpt    <= 1'b0;
      cnt    <= '0;
    end
    else
    begin
      if (lnk.dq_d2c_vld)
      begin
        pack   <= {lnk.dq_d2c, pack[31:8]};
        pack_n <= pack_n + 2'h1;
      end
      if (push)
      begin
        rbuf[wp] <= {lnk.dq_d2c, pack[31:8]};
        wp       <= ~wp;
      end
      if (pop)
      begin
        rpt <= ~rpt;
      end
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ---- src/ddrrt_pkg.sv ----
// Shared constants, types and latency decoders for the read turnaround link
// Summary of operation
// - Field 01 selects chop4 or eight by bit12
// - Eight beats for field 00, or 01 with bit12
// - Two-clock write preamble needs write latency raised
// - Precharge waits additive latency plus read-to-precharge
// - Precharge also waits activate-to-precharge time
// - Activate needs precharge period and row cycle
// - Code 001 means read-to-precharge of 6 clocks
// - Read latency is CAS plus additive latency
// - Parity adds parity latency to read and write latency
// - Read inversion adds two clocks to read data
package ddrrt_pkg;

  // ****************************************************
  // Commands and burst modes
  // ****************************************************
  typedef enum logic [2:0]
  {
    DDRRT_NOP = 3'h0,
    DDRRT_ACT = 3'h1,
    DDRRT_RD  = 3'h2,
    DDRRT_RDA = 3'h3,
    DDRRT_WR  = 3'h4,
    DDRRT_PRE = 3'h5
  } ddrrt_cmd_e;

  localparam logic [1:0] BF_FIXED8 = 2'h0;   // Always eight beats
  localparam logic [1:0] BF_FLY    = 2'h1;   // On the fly select
  localparam logic [1:0] BF_CHOP4  = 2'h2;   // Always four beats
  localparam logic [3:0] BEATS8    = 4'h8;   // Full burst length
  localparam logic [3:0] BEATS4    = 4'h4;   // Chopped burst length

  // ****************************************************
  // Latency constants
  // ****************************************************
  localparam int         LAT_W     = 7;      // Width of latency sums
  localparam int         PIPE_D    = 72;     // Command pipe depth
  localparam logic [3:0] RTP_BASE  = 4'h5;   // Code 0 delay, code 1 gives 6
  localparam logic [4:0] CWL_MIN   = 5'h09;  // Lowest write latency
  localparam logic [6:0] INV_LAT   = 7'h02;  // Extra clocks with inversion
  localparam int         TCK_NS    = 50;     // Clock period
  localparam int         ACTIVATE_TO_PRECHARGE_TIME_NS   = 1000;   // Activate to precharge
  localparam int         TRP_NS    = 550;    // Precharge period
  localparam int         TRC_NS    = 1550;   // Row cycle time
  localparam logic [5:0] ACTIVATE_TO_PRECHARGE_TIME_CYC  = 6'((ACTIVATE_TO_PRECHARGE_TIME_NS + TCK_NS - 1) / TCK_NS);
  localparam logic [5:0] TRP_CYC   = 6'((TRP_NS + TCK_NS - 1) / TCK_NS);
  localparam logic [5:0] TRC_CYC   = 6'((TRC_NS + TCK_NS - 1) / TCK_NS);

  // ****************************************************
  // Controller register map
  // ****************************************************
  localparam logic [7:0] REG_CFG   = 8'h00;  // Mode settings
  localparam logic [7:0] REG_CMD   = 8'h04;  // Command to issue
  localparam logic [7:0] REG_STAT  = 8'h08;  // Status
  localparam logic [7:0] REG_RDATA = 8'h0C;  // Read word, pops buffer
  localparam logic [7:0] REG_WDATA = 8'h10;  // Write word
  localparam logic [8:0] CFG_RST   = 9'h000; // Low config reset

  // Pipe slot: pending burst with its length and column
  typedef struct packed
  {
    logic       vld;
    logic       eight;
    logic [3:0] col;
  } ddrrt_slot_s;

  // ****************************************************
  // Decoders
  // ****************************************************
  // Eight beats or chopped four
  function automatic logic ddrrt_is_eight(input logic [1:0] bf, input logic a12);
    ddrrt_is_eight = (bf == BF_FIXED8) || ((bf == BF_FLY) && a12);
  endfunction

  // Read latency in clocks
  function automatic logic [6:0] ddrrt_rd_lat(input logic [4:0] cl, input logic [4:0] al,
                                              input logic par, input logic [2:0] pl, input logic data_bus_inversion);
    ddrrt_rd_lat = 7'(cl) + 7'(al)
                 + (par ? 7'(pl) : 7'h00)
                 + (data_bus_inversion ? INV_LAT : 7'h00);
  endfunction

  // Write latency in clocks
  function automatic logic [6:0] ddrrt_wr_lat(input logic [4:0] cas_write_latency, input logic [4:0] al,
                                              input logic par, input logic [2:0] pl);
    ddrrt_wr_lat = 7'(cas_write_latency) + 7'(al) + (par ? 7'(pl) : 7'h00);
  endfunction

  // Read to precharge delay from its code
  function automatic logic [3:0] ddrrt_rtp(input logic [2:0] code);
    ddrrt_rtp = RTP_BASE + 4'(code);
  endfunction

endpackage

// ---- src/ddrrt_if.sv ----
// Link between the memory device end and the controller end
`timescale 1ns/1ps
interface ddrrt_if;
  import ddrrt_pkg::*;
  ddrrt_cmd_e cmd;         // Command, one cycle
  logic       a12;         // Burst select bit twelve
  logic [3:0] col;         // Column
  logic [1:0] burst_field; // Mode burst field
  logic [2:0] rtp_code;    // Read to precharge code
  logic [4:0] cl;          // CAS latency
  logic [4:0] al;          // Additive latency
  logic [4:0] cas_write_latency;         // CAS write latency
  logic       par_en;      // Parity enable
  logic [2:0] pl;          // Parity latency
  logic       dbi_en;      // Read inversion enable
  logic [7:0] dq_c2d;      // Write data beat
  logic       dq_c2d_vld;  // Write beat valid
  logic [7:0] dq_d2c;      // Read data beat
  logic       dq_d2c_vld;  // Read beat valid

  // Memory device end
  modport dev (input cmd, a12, col, burst_field, rtp_code, cl, al, cas_write_latency, par_en, pl, dbi_en,
               dq_c2d, dq_c2d_vld, output dq_d2c, dq_d2c_vld);
  // Controller end
  modport ctl (output cmd, a12, col, burst_field, rtp_code, cl, al, cas_write_latency, par_en, pl, dbi_en,
               dq_c2d, dq_c2d_vld, input dq_d2c, dq_d2c_vld);
endinterface

// ---- src/ddrrt_dev.sv ----
// Memory device end: burst select, latencies, auto precharge
`timescale 1ns/1ps
module ddrrt_dev
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Link
  ddrrt_if.dev      lnk,
  // Status
  output logic      bank_open,
  output logic      auto_pre_pending
);
  import ddrrt_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  ddrrt_slot_s rd_pipe [PIPE_D];  // Pending read bursts
  ddrrt_slot_s wr_pipe [PIPE_D];  // Pending write bursts
  logic [7:0]  mem [16];          // Small data store
  logic [6:0]  rl;                // Read latency
  logic [6:0]  wl;                // Write latency
  logic        eight;             // Burst length of this command
  logic        is_rd;             // Read or read with precharge
  logic        is_wr;             // Write command
  ddrrt_slot_s slot;              // Slot for the new command
  logic [3:0]  rd_left;           // Read beats still to send
  logic [3:0]  rd_addr;           // Next read column
  logic [3:0]  wr_left;           // Write beats still to take
  logic [3:0]  wr_addr;           // Next write column
  logic [5:0]  ras_cnt;           // Activate to precharge countdown
  logic [6:0]  apc_cnt;           // Auto precharge countdown

  // ****************************************************
  // Command decode
  // ****************************************************
  // Latencies and burst length for the command on the link
  always_comb
  begin
    rl         = ddrrt_rd_lat(lnk.cl, lnk.al, lnk.par_en, lnk.pl, lnk.dbi_en);
    wl         = ddrrt_wr_lat(lnk.cas_write_latency, lnk.al, lnk.par_en, lnk.pl);
    eight      = ddrrt_is_eight(lnk.burst_field, lnk.a12);
    is_rd      = (lnk.cmd == DDRRT_RD) || (lnk.cmd == DDRRT_RDA);
    is_wr      = (lnk.cmd == DDRRT_WR);
    slot.vld   = 1'b1;
    slot.eight = eight;
    slot.col   = lnk.col;
  end

  // ****************************************************
  // Latency pipes
  // ****************************************************
  // Read pipe: slot reaches index 0 in cycle rl-1, data out in cycle rl
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < PIPE_D; i++)
      begin
        rd_pipe[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < PIPE_D; i++)
      begin
        // Insert new read at its latency slot
        if (is_rd && (7'(i) == rl - 7'h02))
        begin
          rd_pipe[i] <= slot;
        end
        // Shift toward the output
        else if (i < PIPE_D - 1)
        begin
          rd_pipe[i] <= rd_pipe[i + 1];
        end
        // Top slot empties
        else
        begin
          rd_pipe[i] <= '0;
        end
      end
    end
  end

  // Write pipe: slot reaches index 0 in cycle wl, first beat taken there
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < PIPE_D; i++)
      begin
        wr_pipe[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < PIPE_D; i++)
      begin
        // Insert new write at its latency slot
        if (is_wr && (7'(i) == wl - 7'h01))
        begin
          wr_pipe[i] <= slot;
        end
        // Shift toward the output
        else if (i < PIPE_D - 1)
        begin
          wr_pipe[i] <= wr_pipe[i + 1];
        end
        // Top slot empties
        else
        begin
          wr_pipe[i] <= '0;
        end
      end
    end
  end

  // ****************************************************
  // Read burst engine
  // ****************************************************
  // Sends four or eight beats, a new burst takes over at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_left        <= '0;
      rd_addr        <= '0;
      lnk.dq_d2c     <= '0;
      lnk.dq_d2c_vld <= 1'b0;
    end
    else if (rd_pipe[0].vld)
    begin
      // First beat of a burst
      lnk.dq_d2c     <= mem[rd_pipe[0].col];
      lnk.dq_d2c_vld <= 1'b1;
      rd_addr        <= rd_pipe[0].col + 4'h1;
      rd_left        <= (rd_pipe[0].eight ? BEATS8 : BEATS4) - 4'h1;
    end
    else if (rd_left != 4'h0)
    begin
      // Following beats
      lnk.dq_d2c     <= mem[rd_addr];
      lnk.dq_d2c_vld <= 1'b1;
      rd_addr        <= rd_addr + 4'h1;
      rd_left        <= rd_left - 4'h1;
    end
    else
    begin
      // Bus idle
      lnk.dq_d2c_vld <= 1'b0;
    end
  end

  // ****************************************************
  // Write burst engine
  // ****************************************************
  // Takes beat 0 in the slot cycle and the rest after it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_left <= '0;
      wr_addr <= '0;
    end
    else if (wr_pipe[0].vld)
    begin
      // Burst starts
      wr_addr <= wr_pipe[0].col + 4'h1;
      wr_left <= (wr_pipe[0].eight ? BEATS8 : BEATS4) - 4'h1;
    end
    else if (wr_left != 4'h0)
    begin
      // Burst continues
      wr_addr <= wr_addr + 4'h1;
      wr_left <= wr_left - 4'h1;
    end
  end

  // Data store update, no reset on the array
  always_ff @(posedge hclk)
  begin
    if (wr_pipe[0].vld && lnk.dq_c2d_vld)
    begin
      mem[wr_pipe[0].col] <= lnk.dq_c2d;
    end
    else if ((wr_left != 4'h0) && lnk.dq_c2d_vld)
    begin
      mem[wr_addr] <= lnk.dq_c2d;
    end
  end

  // ****************************************************
  // Bank state and auto precharge
  // ****************************************************
  // Activate to precharge minimum since the last activate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ras_cnt <= '0;
    end
    else if (lnk.cmd == DDRRT_ACT)
    begin
      ras_cnt <= ACTIVATE_TO_PRECHARGE_TIME_CYC - 6'h01;
    end
    else if (ras_cnt != 6'h00)
    begin
      ras_cnt <= ras_cnt - 6'h01;
    end
  end

  // Auto precharge: wait AL plus delay and the activate minimum
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      apc_cnt          <= '0;
      auto_pre_pending <= 1'b0;
      bank_open        <= 1'b0;
    end
    else if (lnk.cmd == DDRRT_ACT)
    begin
      // Row opens
      bank_open        <= 1'b1;
      auto_pre_pending <= 1'b0;
    end
    else if (lnk.cmd == DDRRT_PRE)
    begin
      // Explicit precharge closes the row
      bank_open        <= 1'b0;
      auto_pre_pending <= 1'b0;
    end
    else if (lnk.cmd == DDRRT_RDA)
    begin
      // Delay counted from the command
      apc_cnt          <= 7'(lnk.al) + 7'(ddrrt_rtp(lnk.rtp_code)) - 7'h01;
      auto_pre_pending <= 1'b1;
    end
    else if (auto_pre_pending)
    begin
      if (apc_cnt != 7'h00)
      begin
        apc_cnt <= apc_cnt - 7'h01;
      end
      else if (ras_cnt == 6'h00)
      begin
        // Internal precharge begins
        bank_open        <= 1'b0;
        auto_pre_pending <= 1'b0;
      end
    end
  end

endmodule

// ---- verif/ddrrt_properties.sv ----
// Link timing properties for the read turnaround pair
`timescale 1ns/1ps
module ddrrt_properties
(
  // Clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Link
  input wire ddrrt_pkg::ddrrt_cmd_e cmd,
  input wire logic                  a12,
  input wire logic [1:0]            burst_field,
  input wire logic [2:0]            rtp_code,
  input wire logic [4:0]            cl,
  input wire logic [4:0]            al,
  input wire logic                  par_en,
  input wire logic [2:0]            pl,
  input wire logic                  dbi_en,
  input wire logic                  dq_d2c_vld
);
  import ddrrt_pkg::*;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Read with CAS latency 11, no additive part
  wire rdx = (cmd == DDRRT_RD) && (cl == 5'h0b) && (al == 5'h00);
  // Same read with no extras
  wire rd0 = rdx && !par_en && !dbi_en;
  // No precharge on the link this cycle
  wire nopre = (cmd != DDRRT_PRE);
  a_read_lat: assert property (rd0 |-> ##3 (!dq_d2c_vld) [*8] ##1 dq_d2c_vld)
    else $error("read data not at latency 11");
  a_fixed_eight: assert property (rd0 && burst_field == BF_FIXED8 |-> ##11 dq_d2c_vld [*8] ##1 !dq_d2c_vld)
    else $error("fixed burst not eight beats");
  a_fly_eight: assert property (rd0 && burst_field == BF_FLY && a12 |-> ##11 dq_d2c_vld [*8])
    else $error("on the fly burst not eight beats");
  a_chop_four: assert property (rd0 && (burst_field == BF_CHOP4 || burst_field == BF_FLY && !a12)
                                |-> ##11 dq_d2c_vld [*4] ##1 !dq_d2c_vld)
    else $error("chopped burst not four beats");
  a_parity_lat: assert property (rdx && par_en && pl == 3'h4 && !dbi_en |-> ##14 !dq_d2c_vld ##1 dq_d2c_vld)
    else $error("parity read latency wrong");
  a_inversion_lat: assert property (rdx && dbi_en && !par_en |-> ##12 !dq_d2c_vld ##1 dq_d2c_vld)
    else $error("inversion read latency wrong");
  a_additive_lat: assert property (cmd == DDRRT_RD && cl == 5'h0b && al == 5'h09 && !par_en && !dbi_en
                                   |-> ##19 !dq_d2c_vld ##1 dq_d2c_vld)
    else $error("additive read latency wrong");
  a_pre_spacing: assert property (rdx && rtp_code == 3'h1 |-> ##1 (cmd != DDRRT_PRE) [*5])
    else $error("precharge too soon after read");
  a_act_spacing: assert property (cmd == DDRRT_PRE |-> ##3 (cmd != DDRRT_ACT) [*8])
    else $error("activate too soon after precharge");
  a_ras_spacing: assert property (cmd == DDRRT_ACT |-> ##1 nopre [*8] ##1 nopre [*8] ##1 nopre [*3])
    else $error("precharge too soon after activate");
  // Main scenarios
  c_fly_chop: cover property (rd0 && burst_field == BF_FLY && !a12);
  c_auto_pre: cover property (cmd == DDRRT_RDA);
  c_precharge: cover property (cmd == DDRRT_PRE);
endmodule

// ---- verif/ddrrt_bench.sv ----
// Self-checking bench for both link ends over AHB-Lite
`timescale 1ns/1ps
module ddrrt_bench;
  import ddrrt_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, bank_open, apend;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r, word;
  int          error_cnt, checks_done;
  // Modes: burst field, bit twelve, parity, inversion, additive latency
  logic [9:0]  tab [7] = '{10'h000, 10'h180, 10'h100, 10'h200, 10'h040, 10'h220, 10'h009};
  ddrrt_if lnk ();
  ddrrt_dev u_ddrrt_dev (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev), .bank_open(bank_open),
                         .auto_pre_pending(apend));
  ddrrt_ctl u_ddrrt_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
                         .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
                         .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk.ctl));
  ddrrt_properties u_ddrrt_properties (.hclk(hclk), .hresetn(hresetn), .cmd(lnk.cmd), .a12(lnk.a12),
    .burst_field(lnk.burst_field), .rtp_code(lnk.rtp_code), .cl(lnk.cl), .al(lnk.al), .par_en(lnk.par_en),
    .pl(lnk.pl), .dbi_en(lnk.dbi_en), .dq_d2c_vld(lnk.dq_d2c_vld));
  // Clock, 50 ns period
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Verdict and stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare one value
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
    r = hrdata;
    if (n >= 99)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // Wait until no command is pending
  task automatic idle();
    int n;
    n = 0;
    do bus(1'b0, REG_STAT, 32'h0); while (r[0] !== 1'b0 && ++n < 50);
    if (n >= 50)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask
  // Config word: cl 11, rtp code 1, cwl 9, pl 4
  function automatic logic [31:0] cfg(input logic [9:0] t);
    cfg = {7'h00, t[5], 3'h4, t[6], 5'h09, t[4:0], 5'h0b, 3'h1, t[9:8]};
  endfunction
  // Main sequence
  initial
  begin
    logic [9:0] t;
    logic       a;
    logic [1:0] e;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, error_cnt, checks_done} = '0;
    hsize = 3'h2;
    void'($urandom(4035));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, REG_STAT, 32'h0);
    check("status", 32'h0, r);
    check("response", 32'h0, 32'(hresp));
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, r);
    word = $urandom;
    bus(1'b1, REG_WDATA, word);
    // Write burst with parity and two-clock preamble, read back below
    bus(1'b1, REG_CFG, cfg(10'h040) | 32'h0200_0000);
    bus(1'b1, REG_CMD, 32'h1);
    bus(1'b1, REG_CMD, 32'hc);
    idle();
    repeat (30) @(posedge hclk);
    foreach (tab[i])
    begin
      t = tab[i];
      a = (t[9:8] == BF_FLY) ? t[7] : 1'($urandom);
      e = (t[9:8] == BF_FIXED8 || (t[9:8] == BF_FLY && a)) ? 2'h2 : 2'h1;
      bus(1'b1, REG_CFG, cfg(t));
      bus(1'b1, REG_CMD, {28'h000_0000, a, 3'h2});
      repeat (40) @(posedge hclk);
      bus(1'b0, REG_STAT, 32'h0);
      check("buffer count", 32'(e), 32'(r[3:2]));
      repeat (e)
      begin
        bus(1'b0, REG_RDATA, 32'h0);
        check("read word", word, r);
      end
    end
    bus(1'b1, REG_CFG, cfg(10'h000));
    bus(1'b1, REG_CMD, 32'h3);
    repeat (3) @(posedge hclk);
    check("auto precharge pending", 32'h1, 32'(apend));
    repeat (40) @(posedge hclk);
    check("row after auto precharge", 32'h0, {apend, bank_open});
    repeat (2) bus(1'b0, REG_RDATA, 32'h0);
    check("auto precharge word", word, r);
    bus(1'b1, REG_CMD, 32'h1);
    idle();
    check("row open", 32'h1, 32'(bank_open));
    bus(1'b1, REG_CMD, 32'h5);
    idle();
    repeat (2) @(posedge hclk);
    check("row closed", 32'h0, 32'(bank_open));
    bus(1'b1, REG_CMD, 32'h1);
    idle();
    // Read then precharge at once, the controller holds the spacing
    repeat (20) @(posedge hclk);
    bus(1'b1, REG_CMD, 32'h2);
    bus(1'b1, REG_CMD, 32'h5);
    idle();
    end_of_test();
  end
endmodule
